// ---- hdl/i2cse_pkg.sv ----
/*
  Shared constants and types for the two-wire slave protocol engine
  and its bus-master end.
  Assumes a 100 MHz system clock on the master end.
*/
package i2cse_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_NS = 10;          // system clock period
    localparam int T_QTR_NS = 625;       // quarter of a 400 kHz bit time
    localparam int QTR_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;

    // -----------------------------------------------------------------
    // protocol values
    // -----------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [6:0] ADDR_BASE = 7'h40;     // fixed address bits
    localparam logic [1:0] RECOV_TOP = 2'h2;      // top bits of recovery byte
    localparam logic [7:0] RECOV_BYTE = 8'h80;    // recovery byte sent
    localparam logic [2:0] LAST_BIT = 3'h7;

    // device states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WR = 3'h2,
        ST_WACK = 3'h6,
        ST_RD = 3'h7,
        ST_RACK = 3'h5,
        ST_RECOV = 3'h4
    } i2cse_dst_t;

    // master symbol states
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_START = 2'h1,
        H_BITS = 2'h3,
        H_STOP = 2'h2
    } i2cse_hst_t;

    // master commands
    typedef enum logic [2:0] {
        CMD_START = 3'h0,
        CMD_STOP = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_READ = 3'h3,
        CMD_RECOVER = 3'h4
    } i2cse_cmd_t;
endpackage

// ---- hdl/i2cse_bus_if.sv ----
/*
  Two-wire bus between the master end and the slave end.
  Assumes pull-ups: a line is low only while some party drives it low.
*/
`timescale 1ns/1ns
interface i2cse_bus_if;
    // clock line, driven by the master only
    logic scl;
    // data line drivers and resolved level
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // wired-and with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

// ---- hdl/i2cse_device.sv ----
/*
  Slave protocol engine: address match, byte receive and transmit,
  acknowledge and refusal, recovery after start-stop-start.
  Assumes the core inputs (busy, rx_refuse, tx_data) are synchronous
  to clk_link; the bus lines and straps are not and are synchronised.
*/
`timescale 1ns/1ns
module i2cse_device #(
    parameter logic [6:0] ADDR_FIXED = i2cse_pkg::ADDR_BASE
) (
    // link clock and reset
    input wire logic clk_link,
    input wire logic rst,
    // bus
    i2cse_bus_if.dev bus,
    // address straps
    input wire logic addr_strap_lo,
    input wire logic addr_strap_mid,
    input wire logic addr_strap_hi,
    // core side
    input wire logic busy,
    input wire logic rx_refuse,
    input wire logic [7:0] tx_data,
    output logic addressed,
    output logic read_mode,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_next,
    output logic master_nack,
    output logic recovered
);
    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    i2cse_pkg::i2cse_dst_t state;
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [2:0] strap_m, strap_s;
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic in_slot, ack_go, sss, mack, sda_oe;
    logic start_c, stop_c, rise, fall;
    logic active;
    logic [6:0] own_addr;

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    // two flops per line, a third for edge history; straps are static but synchronised too
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            strap_m <= 3'h0;
            strap_s <= 3'h0;
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            strap_m <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
            strap_s <= strap_m;
            scl_m <= bus.scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= bus.sda;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    // -----------------------------------------------------------------
    // bus events and address
    // -----------------------------------------------------------------
    // start and stop are data edges with the clock held high
    assign start_c = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;
    assign active = (state == i2cse_pkg::ST_AACK) | (state == i2cse_pkg::ST_WR) |
                    (state == i2cse_pkg::ST_WACK) | (state == i2cse_pkg::ST_RD) |
                    (state == i2cse_pkg::ST_RACK);
    // straps replace address bits 4, 2 and 0
    assign own_addr = {ADDR_FIXED[6:5], strap_s[2], ADDR_FIXED[3], strap_s[1],
                       ADDR_FIXED[1], strap_s[0]};

    // open drain: only ever pulls low, clock never touched
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe;
    assign addressed = (state == i2cse_pkg::ST_WR) | (state == i2cse_pkg::ST_WACK) |
                       (state == i2cse_pkg::ST_RD) | (state == i2cse_pkg::ST_RACK);

    // -----------------------------------------------------------------
    // protocol engine
    // -----------------------------------------------------------------
    // byte framing, acknowledge slots and transmit shifting
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            state <= i2cse_pkg::ST_IDLE;
            cnt <= 3'h0;
            shreg <= 8'h00;
            in_slot <= 1'b0;
            ack_go <= 1'b0;
            read_mode <= 1'b0;
            sss <= 1'b0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            tx_next <= 1'b0;
            master_nack <= 1'b0;
            recovered <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            tx_next <= 1'b0;
            master_nack <= 1'b0;
            recovered <= 1'b0;
            if (active && start_c) begin
                state <= i2cse_pkg::ST_ADDR;
                cnt <= 3'h0;
                sda_oe <= 1'b0;
            end else if (active && stop_c) begin
                state <= i2cse_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    i2cse_pkg::ST_IDLE: begin
                        if (start_c) begin
                            state <= i2cse_pkg::ST_ADDR;
                            cnt <= 3'h0;
                        end
                    end
                    i2cse_pkg::ST_ADDR: begin
                        // conditions only realign the byte; a stop whose own pulse is the
                        // only rise seen since the start marks start-stop-start
                        if (stop_c || start_c) begin
                            cnt <= 3'h0;
                            if (stop_c && cnt < 3'h2) begin
                                sss <= 1'b1;
                            end
                        end else if (rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            cnt <= cnt + 3'h1;
                            if (cnt == i2cse_pkg::LAST_BIT) begin
                                in_slot <= 1'b0;
                                read_mode <= sda_s;
                                if (sss && shreg[6:5] == i2cse_pkg::RECOV_TOP) begin
                                    ack_go <= 1'b0;
                                    state <= i2cse_pkg::ST_RECOV;
                                end else begin
                                    ack_go <= (shreg[6:0] == own_addr) & ~busy;
                                    state <= i2cse_pkg::ST_AACK;
                                end
                            end
                        end
                    end
                    i2cse_pkg::ST_RECOV: begin
                        // wait out the ack slot after the recovery byte, then its stop
                        if (stop_c) begin
                            sss <= 1'b0;
                            recovered <= 1'b1;
                            state <= i2cse_pkg::ST_IDLE;
                        end
                    end
                    i2cse_pkg::ST_AACK: begin
                        if (fall && !in_slot) begin
                            sda_oe <= ack_go;
                            in_slot <= 1'b1;
                        end else if (fall) begin
                            in_slot <= 1'b0;
                            cnt <= 3'h0;
                            if (!ack_go) begin
                                sda_oe <= 1'b0;
                                state <= i2cse_pkg::ST_IDLE;
                            end else if (read_mode) begin
                                sda_oe <= ~tx_data[7];
                                shreg <= {tx_data[6:0], 1'b0};
                                tx_next <= 1'b1;
                                state <= i2cse_pkg::ST_RD;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= i2cse_pkg::ST_WR;
                            end
                        end
                    end
                    i2cse_pkg::ST_WR: begin
                        if (rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            cnt <= cnt + 3'h1;
                            if (cnt == i2cse_pkg::LAST_BIT) begin
                                rx_data <= {shreg[6:0], sda_s};
                                rx_valid <= 1'b1;
                                in_slot <= 1'b0;
                                state <= i2cse_pkg::ST_WACK;
                            end
                        end
                    end
                    i2cse_pkg::ST_WACK: begin
                        if (fall && !in_slot) begin
                            sda_oe <= ~rx_refuse;
                            in_slot <= 1'b1;
                        end else if (fall) begin
                            sda_oe <= 1'b0;
                            in_slot <= 1'b0;
                            state <= i2cse_pkg::ST_WR;
                        end
                    end
                    i2cse_pkg::ST_RD: begin
                        // next bit goes out on the fall ending the last one
                        if (fall) begin
                            sda_oe <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                        end
                        if (rise) begin
                            cnt <= cnt + 3'h1;
                            if (cnt == i2cse_pkg::LAST_BIT) begin
                                in_slot <= 1'b0;
                                state <= i2cse_pkg::ST_RACK;
                            end
                        end
                    end
                    i2cse_pkg::ST_RACK: begin
                        if (rise) begin
                            mack <= ~sda_s;
                        end
                        if (fall && !in_slot) begin
                            sda_oe <= 1'b0;
                            in_slot <= 1'b1;
                        end else if (fall) begin
                            in_slot <= 1'b0;
                            cnt <= 3'h0;
                            if (mack) begin
                                sda_oe <= ~tx_data[7];
                                shreg <= {tx_data[6:0], 1'b0};
                                tx_next <= 1'b1;
                                state <= i2cse_pkg::ST_RD;
                            end else begin
                                sda_oe <= 1'b0;
                                master_nack <= 1'b1;
                                state <= i2cse_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= i2cse_pkg::ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ---- hdl/i2cse_host.sv ----
/*
  Bus master end: generates the clock from the system clock and runs
  start, stop, byte write, byte read and recovery commands.
  Assumes commands come from logic on clk_sys.
*/
`timescale 1ns/1ns
module i2cse_host #(
    parameter int QTR = i2cse_pkg::QTR_CYC
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus
    i2cse_bus_if.host bus,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire i2cse_pkg::i2cse_cmd_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    // response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    output logic rsp_refused
);
    if (QTR < 1 || QTR > 65536) begin : g_bad_qtr
        $error("QTR must be 1 to 65536 cycles");
    end

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    i2cse_pkg::i2cse_hst_t state;
    logic [15:0] qcnt;
    logic [1:0] phase;
    logic [3:0] nbit;
    logic [7:0] shreg;
    logic is_rd, last, chain, need_rs, rec_need, bit_in;
    logic [1:0] hist;
    logic scl, sda_lvl, sda_m, sda_s;
    logic tick, cur_bit;

    // levels {scl, sda} for a symbol phase
    function automatic logic [1:0] sym(i2cse_pkg::i2cse_hst_t k, logic [1:0] p, logic b);
        logic hi;
        hi = (p == 2'h1) | (p == 2'h2);
        case (k)
            i2cse_pkg::H_START: sym = {hi, p < 2'h2};
            i2cse_pkg::H_STOP: sym = {p != 2'h0, p >= 2'h2};
            default: sym = {hi, b};
        endcase
    endfunction

    // -----------------------------------------------------------------
    // pins and timing
    // -----------------------------------------------------------------
    assign bus.scl = scl;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = ~sda_lvl;
    assign cmd_ready = (state == i2cse_pkg::H_IDLE);
    assign tick = (qcnt == 16'(QTR - 1));
    // ack slot of a read: high releases, i.e. nack on the last byte
    assign cur_bit = (nbit == 4'h8) ? (is_rd ? last : 1'b1) : (is_rd | shreg[7]);

    // data line synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= bus.sda;
            sda_s <= sda_m;
        end
    end

    // quarter-bit divider, runs only while a symbol is out
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            qcnt <= 16'h0000;
        end else if (state == i2cse_pkg::H_IDLE || tick) begin
            qcnt <= 16'h0000;
        end else begin
            qcnt <= qcnt + 16'h0001;
        end
    end

    // -----------------------------------------------------------------
    // command sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= i2cse_pkg::H_IDLE;
            phase <= 2'h0;
            nbit <= 4'h0;
            shreg <= 8'h00;
            is_rd <= 1'b0;
            last <= 1'b0;
            chain <= 1'b0;
            need_rs <= 1'b0;
            rec_need <= 1'b0;
            hist <= 2'h0;
            bit_in <= 1'b1;
            scl <= 1'b1;
            sda_lvl <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
            rsp_refused <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                i2cse_pkg::H_IDLE: begin
                    phase <= 2'h0;
                    nbit <= 4'h0;
                    if (cmd_valid) begin
                        case (cmd_op)
                            i2cse_pkg::CMD_START, i2cse_pkg::CMD_RECOVER: begin
                                // start after start-stop must be followed by recovery
                                rec_need <= (cmd_op == i2cse_pkg::CMD_START) &
                                            (rec_need | (hist == 2'h2));
                                chain <= (cmd_op == i2cse_pkg::CMD_RECOVER);
                                hist <= 2'h1;
                                need_rs <= 1'b0;
                                {scl, sda_lvl} <= sym(i2cse_pkg::H_START, 2'h0, 1'b1);
                                state <= i2cse_pkg::H_START;
                            end
                            i2cse_pkg::CMD_STOP: begin
                                hist <= (hist == 2'h1) ? 2'h2 : 2'h0;
                                {scl, sda_lvl} <= sym(i2cse_pkg::H_STOP, 2'h0, 1'b1);
                                state <= i2cse_pkg::H_STOP;
                            end
                            i2cse_pkg::CMD_WRITE, i2cse_pkg::CMD_READ: begin
                                if (need_rs || rec_need) begin
                                    rsp_valid <= 1'b1;
                                    rsp_refused <= 1'b1;
                                    rsp_nack <= 1'b1;
                                end else begin
                                    hist <= 2'h0;
                                    is_rd <= (cmd_op == i2cse_pkg::CMD_READ);
                                    last <= cmd_last;
                                    shreg <= cmd_data;
                                    {scl, sda_lvl} <= sym(i2cse_pkg::H_BITS, 2'h0,
                                        (cmd_op == i2cse_pkg::CMD_READ) | cmd_data[7]);
                                    state <= i2cse_pkg::H_BITS;
                                end
                            end
                            default: begin
                                rsp_valid <= 1'b1;
                                rsp_refused <= 1'b1;
                            end
                        endcase
                    end
                end
                default: begin
                    if (tick && phase == 2'h2) begin
                        bit_in <= sda_s; // sampled while clock high
                    end
                    if (tick && phase != 2'h3) begin
                        phase <= phase + 2'h1;
                        {scl, sda_lvl} <= sym(state, phase + 2'h1, cur_bit);
                    end else if (tick) begin
                        phase <= 2'h0;
                        if (state == i2cse_pkg::H_START && chain) begin
                            // recovery: one byte, ack slot, then stop
                            is_rd <= 1'b0;
                            shreg <= i2cse_pkg::RECOV_BYTE;
                            nbit <= 4'h0;
                            {scl, sda_lvl} <= sym(i2cse_pkg::H_BITS, 2'h0, i2cse_pkg::RECOV_BYTE[7]);
                            state <= i2cse_pkg::H_BITS;
                        end else if (state == i2cse_pkg::H_BITS && nbit != 4'h8) begin
                            shreg <= {shreg[6:0], bit_in};
                            nbit <= nbit + 4'h1;
                            {scl, sda_lvl} <= sym(i2cse_pkg::H_BITS, 2'h0,
                                (nbit == 4'h7) ? (is_rd ? last : 1'b1) : (is_rd | shreg[6]));
                        end else if (state == i2cse_pkg::H_BITS) begin
                            rsp_valid <= 1'b1;
                            rsp_data <= shreg;
                            rsp_refused <= 1'b0;
                            rsp_nack <= bit_in;
                            need_rs <= ~is_rd & bit_in & ~chain;
                            if (chain) begin
                                {scl, sda_lvl} <= sym(i2cse_pkg::H_STOP, 2'h0, 1'b1);
                                state <= i2cse_pkg::H_STOP;
                            end else begin
                                state <= i2cse_pkg::H_IDLE;
                            end
                        end else begin
                            chain <= 1'b0;
                            state <= i2cse_pkg::H_IDLE;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// ---- testbench/i2cse_monitor.sv ----
/* wire checks on the two-wire bus.
   assumes the device end's link clock and reset */
`timescale 1ns/1ns
module i2cse_monitor (
    // link clock and reset
    input wire logic clk_link,
    input wire logic rst,
    // bus lines
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking @(posedge clk_link); endclocking
    default disable iff (rst);
    // clock line high for two samples
    sequence scl_hi;
        scl && $past(scl);
    endsequence
    // data drive rules
    drain_only_a: assert property (dev_sda_o == 1'b0 && host_sda_o == 1'b0)
        else $error("sda driven high");
    dev_hold_a: assert property (scl_hi |-> $stable(dev_sda_oe))
        else $error("device sda moved while scl high");
    host_hold_a: assert property (scl_hi ##0 $changed(host_sda_oe) |-> $changed(sda))
        else $error("master sda moved outside start or stop");
    dev_change_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
        else $error("device sda not changed after fall");
    ack_hold_a: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe [*3])
        else $error("device low not held through high");
    start_host_a: assert property (scl_hi ##0 $fell(sda) |-> host_sda_oe && !dev_sda_oe)
        else $error("start not made by master");
    stop_free_a: assert property (scl_hi ##0 $rose(sda) |-> !dev_sda_oe)
        else $error("device holds sda at stop");
    no_fight_a: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
        else $error("both ends drive sda in high");
endmodule

// ---- testbench/tb_top.sv ----
/* testbench: master end drives device end over the bus.
   assumes design files compiled first */
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 0, clk_link = 0, rst = 1, cmd_valid = 0, cmd_last = 0, busy = 0, rx_refuse = 0;
    logic cmd_ready, rsp_valid, rsp_nack, rsp_refused, addressed, read_mode, rx_valid, tx_next, master_nack;
    logic recovered, addr_strap_lo, addr_strap_mid, addr_strap_hi;
    logic [7:0] cmd_data = 8'h00, tx_data = 8'h00, rsp_data, rx_data, adr, d;
    logic [3:0] ex;
    logic [31:0] seed = 32'h00000053;
    i2cse_pkg::i2cse_cmd_t cmd_op = i2cse_pkg::CMD_START;
    int num_errors = 0, cmp_count = 0, cyc = 0, mn_cnt = 0, rec_cnt = 0;
    logic [3:0] expq[$];
    logic [7:0] txq[$], rxq[$];
    always #5 clk_sys = ~clk_sys;
    always #3 clk_link = ~clk_link;
    i2cse_bus_if bus ();
    i2cse_host #(.QTR(4)) i2cse_host_i (.clk_sys(clk_sys), .rst(rst), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_nack(rsp_nack), .rsp_refused(rsp_refused));
    i2cse_device i2cse_device_i (.clk_link(clk_link), .rst(rst), .bus(bus), .addr_strap_lo(addr_strap_lo),
        .addr_strap_mid(addr_strap_mid), .addr_strap_hi(addr_strap_hi), .busy(busy), .rx_refuse(rx_refuse),
        .tx_data(tx_data), .addressed(addressed), .read_mode(read_mode), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_next(tx_next), .master_nack(master_nack), .recovered(recovered));
    i2cse_monitor i2cse_monitor_i (.clk_link(clk_link), .rst(rst), .scl(bus.scl), .host_sda_o(bus.host_sda_o),
        .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one command; expect bits are {response, read, refused, nack}
    task automatic cmd(input i2cse_pkg::i2cse_cmd_t op, input logic [7:0] b, input logic l, input logic [3:0] e);
        @(posedge clk_sys);
        #1 {cmd_op, cmd_data, cmd_last, cmd_valid} = {op, b, l, 1'b1};
        if (e[3]) expq.push_back(e);
        @(posedge clk_sys);
        #1 cmd_valid = 0;
        while (cmd_ready !== 1'b1) @(posedge clk_sys) #1;
    endtask
    // response watcher and hang limit
    always @(posedge clk_sys) begin
        cyc++;
        if (rsp_valid === 1'b1) begin
            ex = expq.pop_front();
            chk(rsp_refused === ex[1] && (ex[1] || rsp_nack === ex[0]), "response flags");
            if (ex[2]) chk(rsp_data === txq.pop_front(), "read byte");
        end
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // device core side: feed read bytes, watch received bytes
    always @(posedge clk_link) begin
        if (tx_next === 1'b1) txq.push_back(tx_data);
        if (tx_next === 1'b1) tx_data <= #1 xs();
        if (tx_next === 1'b1) chk(addressed === 1'b1 && read_mode === 1'b1, "read phase flags");
        if (rx_valid === 1'b1) chk(addressed === 1'b1 && read_mode === 1'b0, "write phase flags");
        if (rx_valid === 1'b1) chk(rx_data === rxq.pop_front(), "received byte");
        mn_cnt += int'(master_nack === 1'b1);
        rec_cnt += int'(recovered === 1'b1);
    end
    assign {addr_strap_hi, addr_strap_mid, addr_strap_lo} = {adr[5], adr[3], adr[1]};
    initial begin
        d = xs();
        adr = {2'h2, d[2], 1'b0, d[1], 1'b0, d[0], 1'b0};
        repeat (5) @(posedge clk_sys);
        #1 rst = 0;
        repeat (3) @(posedge clk_sys);
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr, 0, 4'h8);
        d = xs();
        rxq.push_back(d);
        cmd(i2cse_pkg::CMD_WRITE, d, 0, 4'h8);
        d = xs();
        rxq.push_back(d);
        rx_refuse = 1;
        cmd(i2cse_pkg::CMD_WRITE, d, 0, 4'h9);
        rx_refuse = 0;
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr | 8'h01, 0, 4'h8);
        cmd(i2cse_pkg::CMD_READ, 8'h00, 0, 4'hC);
        cmd(i2cse_pkg::CMD_READ, 8'h00, 1, 4'hD);
        cmd(i2cse_pkg::CMD_STOP, 8'h00, 0, 4'h0);
        busy = 1;
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr, 0, 4'h9);
        cmd(i2cse_pkg::CMD_WRITE, xs(), 0, 4'hA);
        busy = 0;
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr ^ 8'h02, 0, 4'h9);
        cmd(i2cse_pkg::CMD_STOP, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_STOP, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr, 0, 4'hA);
        cmd(i2cse_pkg::CMD_RECOVER, 8'h00, 0, 4'h9);
        cmd(i2cse_pkg::CMD_START, 8'h00, 0, 4'h0);
        cmd(i2cse_pkg::CMD_WRITE, adr, 0, 4'h8);
        cmd(i2cse_pkg::CMD_STOP, 8'h00, 0, 4'h0);
        repeat (20) @(posedge clk_sys);
        chk(mn_cnt == 1 && rec_cnt == 1 && expq.size() == 0, "pulse counts");
        conclude();
    end
endmodule
